// file: rtl/status_pkg.sv
// status_pkg: shared constants and carriers for the event/alarm status groups.
// assumes commands arrive already parsed, one per cycle, on the mclk domain.
//
// How it works
// - enable mask picks standard events for summary
// - clear-status or event read empties standard events
// - mask zeroed by write 0 or power-on clear
// - completion command sets event bit 0
// - error classes set standard bits 2 to 5
// - bit 7 marks power cycled since read
// - alarm condition follows each level sample
// - active alarms latch into alarm events
// - alarm enable mask picks alarm summary bits
// - clear-status or event read empties alarm events
// - alarm mask zeroed by write 0 or power-on clear
// - alarm bits: upper, setpoints, lower, rate
// - bit 5 reference sensors agree, bit 6 dielectric
// - four-deep queue, overflow drops and logs error
// - completion command executes in queue order
// - completion raises service request when both masks pass
// - completion query replies one, sets nothing
// - persistent remote units, percent command selects percent
// - units query returns code, zero means percent
// - status bit 2 while enabled alarm events set
// - status bit 5 while enabled standard events set
// - latched events are not counted again
package status_pkg;

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int        STD_OPC        = 0;      // operation complete
  localparam int        STD_QUERY_ERR  = 2;      // query error
  localparam int        STD_DEVICE_ERR = 3;      // device error
  localparam int        STD_EXEC_ERR   = 4;      // execution error
  localparam int        STD_CMD_ERR    = 5;      // command error
  localparam int        STD_POWER_ON   = 7;      // power cycled
  localparam logic [7:0] STD_USED_MASK = 8'hbd;  // bits 1 and 6 unused
  localparam int        ALM_UPPER      = 0;      // upper_level_flag
  localparam int        ALM_SETPOINT_A = 1;      // first setpoint
  localparam int        ALM_SETPOINT_B = 2;      // second setpoint
  localparam int        ALM_LOWER      = 3;      // lower_level_flag
  localparam int        ALM_RATE       = 4;      // rate alarm
  localparam int        ALM_REF_SAME   = 5;      // reference sensors agree
  localparam int        ALM_DIELECTRIC = 6;      // dielectric over limit
  localparam logic [7:0] ALM_USED_MASK = 8'h7f;  // bit 7 unused
  localparam int        STB_OPC_BIT    = 5;      // status byte enable bit

  // ----------------------------------------------------------------
  // reset values, codes, sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic        PSC_RESET      = 1'h1;
  localparam logic [1:0]  UNITS_PERCENT  = 2'h0;
  localparam logic [1:0]  UNITS_RESET    = 2'h0;
  localparam logic [7:0]  OPC_REPLY      = 8'h01;  // character "1"
  localparam logic [15:0] ERR_OVERFLOW   = 16'hfed1; // -303
  localparam int          QUEUE_DEPTH    = 4;

  // ----------------------------------------------------------------
  // command set and carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_CLS       = 4'h0,  // clear status
    OP_ESE       = 4'h1,  // write standard enable mask
    OP_ESE_Q     = 4'h2,  // read standard enable mask
    OP_ESR_Q     = 4'h3,  // read and clear standard events
    OP_ALM_ENA   = 4'h4,  // write alarm enable mask
    OP_ALM_ENA_Q = 4'h5,  // read alarm enable mask
    OP_ALM_EVT_Q = 4'h6,  // read and clear alarm events
    OP_ALM_CON_Q = 4'h7,  // read alarm condition
    OP_OPC       = 4'h8,  // operation complete command
    OP_OPC_Q     = 4'h9,  // operation complete query
    OP_PERCENT   = 4'ha,  // remote units to percent
    OP_UNITS_Q   = 4'hb,  // read remote units
    OP_PSC       = 4'hc,  // write power-on clear setting
    OP_PSC_Q     = 4'hd,  // read power-on clear setting
    OP_OTHER     = 4'hf   // handled elsewhere
  } opcode_t;

  typedef struct packed {
    opcode_t    op;      // what to do
    logic [7:0] value;   // decimal argument as binary
    logic       src;     // 0 serial, 1 parallel bus
  } cmd_t;

  typedef struct packed {
    logic [7:0] value;   // number to print
    logic       units;   // follow the number with the units word
    logic       dst;     // interface that asked
  } reply_t;

endpackage

// file: rtl/sticky_flags.sv
// sticky_flags: a row of event latches; a set in the clearing cycle survives.
// assumes set and clr come from logic on mclk.
module sticky_flags #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // a latched bit ignores repeats; set wins over clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flags <= {W{1'b0}};
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

endmodule

// file: rtl/command_queue.sv
// command_queue: four-slot first-in first-out store for parsed commands.
// assumes one offer per cycle; an offer while full is dropped, not stalled.
module command_queue (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              in_valid,
  input  status_pkg::cmd_t       in_cmd,
  output logic                   full,
  output logic                   overflow,
  output logic                   out_valid,
  output status_pkg::cmd_t       out_cmd,
  input  wire logic              out_ready
);

  status_pkg::cmd_t slots [status_pkg::QUEUE_DEPTH];  // storage
  logic [1:0]       wr_ptr;                           // next free slot
  logic [1:0]       rd_ptr;                           // oldest slot
  logic [2:0]       count;                            // slots in use
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  // full is judged before a same-cycle pop, so the host sees a clean limit
  assign full      = (count == 3'(status_pkg::QUEUE_DEPTH));
  assign out_valid = (count != 3'h0);
  assign push      = in_valid && !full;
  assign pop       = out_valid && out_ready;
  assign overflow  = in_valid && full;
  assign out_cmd   = slots[rd_ptr];

  // store in arrival order
  always_ff @(posedge mclk) begin
    if (push) begin
      slots[wr_ptr] <= in_cmd;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 3'h0;
    end else begin
      wr_ptr <= wr_ptr + 2'(push);
      rd_ptr <= rd_ptr + 2'(pop);
      count  <= count + 3'(push) - 3'(pop);
    end
  end

endmodule

// file: rtl/event_alarm_status_groups.sv
// event_alarm_status_groups: standard event and alarm register groups with
// their enable masks, the command queue, completion signalling and the
// remote units setting.
// assumes a parser on mclk hands over decoded commands; reset_n low is a
// power cycle; non-volatile state is held by the surrounding supply domain.
module event_alarm_status_groups (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               nvram_blank,
  input  wire logic               cmd_valid,
  input  status_pkg::cmd_t        cmd,
  input  wire logic               exec_ready,
  input  wire logic               err_query,
  input  wire logic               err_device,
  input  wire logic               err_exec,
  input  wire logic               err_cmd,
  input  wire logic               sample_valid,
  input  wire logic [6:0]         alarm_now,
  input  wire logic [7:0]         sre_mask,
  output logic                    queue_full,
  output logic                    overflow_err,
  output logic [15:0]             overflow_code,
  output logic                    exec_valid,
  output status_pkg::cmd_t        exec_cmd,
  output logic                    reply_valid,
  output status_pkg::reply_t      reply,
  output logic                    std_summary,
  output logic                    alarm_summary,
  output logic                    srq_opc,
  output logic [1:0]              remote_units
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic             q_valid;      // queue head present
  logic             q_overflow;   // offer dropped this cycle
  logic             just_reset;   // first cycle after power-up
  logic             take;         // head executes this cycle
  logic [7:0]       std_flags;    // standard_event_flags
  logic [7:0]       std_set;      // standard event sources
  logic [7:0]       std_clr;      // standard event clear
  logic [7:0]       ese;          // standard event enable mask
  logic [7:0]       alarm_cond;   // alarm_live_state
  logic [7:0]       alm_flags;    // alarm_latched_flags
  logic [7:0]       alm_set;      // alarm event sources
  logic [7:0]       alm_clr;      // alarm event clear
  logic [7:0]       alm_ena;      // alarm event enable mask
  logic             psc;          // power-on clear setting
  logic             opc_done;     // completion command retires
  logic             clear_all;    // clear-status retires

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  // true when the head command of the given kind retires this cycle
  function automatic logic runs(input logic go, input status_pkg::cmd_t c,
                                input status_pkg::opcode_t o);
    runs = go && (c.op == o);
  endfunction

  // ----------------------------------------------------------------
  // command queue
  // ----------------------------------------------------------------
  // no stall toward the host: a fifth pending command is simply lost
  command_queue u_queue (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (cmd_valid),
    .in_cmd    (cmd),
    .full      (queue_full),
    .overflow  (q_overflow),
    .out_valid (q_valid),
    .out_cmd   (exec_cmd),
    .out_ready (exec_ready)
  );

  // the rest of the instrument paces execution with exec_ready
  assign exec_valid    = q_valid;
  assign take          = q_valid && exec_ready;
  assign opc_done      = runs(take, exec_cmd, status_pkg::OP_OPC);
  assign clear_all     = runs(take, exec_cmd, status_pkg::OP_CLS);
  assign overflow_code = status_pkg::ERR_OVERFLOW;

  // overflow report for the error buffer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      overflow_err <= 1'b0;
    end else begin
      overflow_err <= q_overflow;
    end
  end

  // ----------------------------------------------------------------
  // power-up marker
  // ----------------------------------------------------------------
  // high for exactly one cycle after reset release
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      just_reset <= 1'b1;
    end else begin
      just_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // standard event group
  // ----------------------------------------------------------------
  // sources; unused positions never get a set
  always_comb begin
    std_set = 8'h00;
    std_set[status_pkg::STD_OPC]        = opc_done;
    std_set[status_pkg::STD_QUERY_ERR]  = err_query;
    std_set[status_pkg::STD_DEVICE_ERR] = err_device;
    std_set[status_pkg::STD_EXEC_ERR]   = err_exec || q_overflow;
    std_set[status_pkg::STD_CMD_ERR]    = err_cmd;
    std_set[status_pkg::STD_POWER_ON]   = just_reset;
  end

  // reading the register also empties it
  assign std_clr = {8{clear_all || runs(take, exec_cmd, status_pkg::OP_ESR_Q)}};

  sticky_flags #(.W(8)) u_std (
    .mclk    (mclk),
    .reset_n (reset_n),
    .set     (std_set),
    .clr     (std_clr),
    .flags   (std_flags)
  );

  // ----------------------------------------------------------------
  // alarm group
  // ----------------------------------------------------------------
  // condition follows each new level sample, bit 7 held low
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alarm_cond <= 8'h00;
    end else if (sample_valid) begin
      alarm_cond <= {1'b0, alarm_now};
    end
  end

  // any active alarm in the sample latches; no wait for the condition copy
  assign alm_set = sample_valid ? {1'b0, alarm_now} : 8'h00;
  assign alm_clr = {8{clear_all || runs(take, exec_cmd, status_pkg::OP_ALM_EVT_Q)}};

  sticky_flags #(.W(8)) u_alarm (
    .mclk    (mclk),
    .reset_n (reset_n),
    .set     (alm_set),
    .clr     (alm_clr),
    .flags   (alm_flags)
  );

  // ----------------------------------------------------------------
  // enable masks
  // ----------------------------------------------------------------
  // kept across power cycles unless power-on clear is set or the store is blank; clear status
  // leaves them alone
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      if (nvram_blank || psc) begin
        ese     <= status_pkg::MASK_RESET;
        alm_ena <= status_pkg::MASK_RESET;
      end
    end else begin
      if (runs(take, exec_cmd, status_pkg::OP_ESE)) begin
        ese <= exec_cmd.value;
      end
      if (runs(take, exec_cmd, status_pkg::OP_ALM_ENA)) begin
        alm_ena <= exec_cmd.value;
      end
    end
  end

  // ----------------------------------------------------------------
  // persistent settings
  // ----------------------------------------------------------------
  // only a blank non-volatile store resets these
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      if (nvram_blank) begin
        psc          <= status_pkg::PSC_RESET;
        remote_units <= status_pkg::UNITS_RESET;
      end
    end else begin
      if (runs(take, exec_cmd, status_pkg::OP_PSC)) begin
        psc <= (exec_cmd.value != 8'h00);
      end
      if (runs(take, exec_cmd, status_pkg::OP_PERCENT)) begin
        remote_units <= status_pkg::UNITS_PERCENT;
      end
    end
  end

  // ----------------------------------------------------------------
  // status byte feeds and completion request
  // ----------------------------------------------------------------
  // registered one cycle behind the flags they summarise
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      std_summary   <= 1'b0;
      alarm_summary <= 1'b0;
      srq_opc       <= 1'b0;
    end else begin
      std_summary   <= |(std_flags & ese);
      alarm_summary <= |(alm_flags & alm_ena);
      srq_opc       <= opc_done && ese[status_pkg::STD_OPC]
                       && sre_mask[status_pkg::STB_OPC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // query replies
  // ----------------------------------------------------------------
  // one reply per query, addressed back to the asking interface
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reply_valid <= 1'b0;
      reply       <= '{value: 8'h00, units: 1'b0, dst: 1'b0};
    end else begin
      reply_valid <= 1'b0;
      reply.units <= 1'b0;
      reply.dst   <= exec_cmd.src;
      if (take) begin
        case (exec_cmd.op)
          status_pkg::OP_ESE_Q: begin
            reply_valid <= 1'b1;
            reply.value <= ese;
          end
          status_pkg::OP_ESR_Q: begin
            reply_valid <= 1'b1;
            reply.value <= std_flags & status_pkg::STD_USED_MASK;
          end
          status_pkg::OP_ALM_ENA_Q: begin
            reply_valid <= 1'b1;
            reply.value <= alm_ena;
          end
          status_pkg::OP_ALM_EVT_Q: begin
            reply_valid <= 1'b1;
            reply.value <= alm_flags & status_pkg::ALM_USED_MASK;
          end
          status_pkg::OP_ALM_CON_Q: begin
            reply_valid <= 1'b1;
            reply.value <= alarm_cond & status_pkg::ALM_USED_MASK;
          end
          status_pkg::OP_OPC_Q: begin
            reply_valid <= 1'b1;
            reply.value <= status_pkg::OPC_REPLY;
          end
          status_pkg::OP_UNITS_Q: begin
            reply_valid <= 1'b1;
            reply.value <= {6'h00, remote_units};
            reply.units <= 1'b1;
          end
          status_pkg::OP_PSC_Q: begin
            reply_valid <= 1'b1;
            reply.value <= {7'h00, psc};
          end
          default: begin
            reply_valid <= 1'b0;  // commands give no reply
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_esr_clears;
    @(posedge mclk) disable iff (!reset_n)
    runs(take, exec_cmd, status_pkg::OP_ESR_Q) |=> (std_flags == $past(std_set));
  endproperty
  a_esr_clears: assert property (p_esr_clears) else $error("event read did not clear");

  property p_ese_zero;
    @(posedge mclk) disable iff (!reset_n)
    (runs(take, exec_cmd, status_pkg::OP_ESE) && exec_cmd.value == 8'h00) |=> (ese == 8'h00);
  endproperty
  a_ese_zero: assert property (p_ese_zero) else $error("enable mask not zeroed");

  property p_opc_sets;
    @(posedge mclk) disable iff (!reset_n)
    opc_done |=> std_flags[status_pkg::STD_OPC]
      && (srq_opc == ($past(ese[0]) && $past(sre_mask[5])));
  endproperty
  a_opc_sets: assert property (p_opc_sets) else $error("completion bit or request wrong");

  property p_cmd_err;
    @(posedge mclk) disable iff (!reset_n)
    err_cmd |=> std_flags[status_pkg::STD_CMD_ERR];
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("command error not latched");

  property p_power_on;
    @(posedge mclk) disable iff (!reset_n)
    just_reset |=> std_flags[status_pkg::STD_POWER_ON] ##1 !just_reset;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on bit missing");

  property p_cond_tracks;
    @(posedge mclk) disable iff (!reset_n)
    sample_valid |=> (alarm_cond == {1'b0, $past(alarm_now)});
  endproperty
  a_cond_tracks: assert property (p_cond_tracks) else $error("condition missed sample");

  property p_latch_holds;
    @(posedge mclk) disable iff (!reset_n)
    (alm_clr == 8'h00) |=> ((alm_flags & $past(alm_flags)) == $past(alm_flags));
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("alarm event dropped");

  property p_overflow;
    @(posedge mclk) disable iff (!reset_n)
    (cmd_valid && queue_full) |=> overflow_err && std_flags[status_pkg::STD_EXEC_ERR];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not reported");

  property p_opc_query;
    @(posedge mclk) disable iff (!reset_n)
    runs(take, exec_cmd, status_pkg::OP_OPC_Q)
      |=> reply_valid && reply.value == 8'h01 && !$rose(std_flags[0]);
  endproperty
  a_opc_query: assert property (p_opc_query) else $error("completion query reply wrong");

  property p_alarm_summary;
    @(posedge mclk) disable iff (!reset_n)
    ##1 (alarm_summary == $past(|(alm_flags & alm_ena)));
  endproperty
  a_alarm_summary: assert property (p_alarm_summary) else $error("alarm summary wrong");

  property p_std_summary;
    @(posedge mclk) disable iff (!reset_n)
    ##1 (std_summary == $past(|(std_flags & ese)));
  endproperty
  a_std_summary: assert property (p_std_summary) else $error("event summary wrong");

  property p_unused_zero;
    @(posedge mclk) disable iff (!reset_n)
    !std_flags[1] && !std_flags[6] && !alm_flags[7] && !alarm_cond[7];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

endmodule

// file: sim/host_model.sv
// host_model: remote host that offers parsed commands and paces execution.
// assumes mclk from the bench; it drives 1 ns after each rising edge.
module host_model (
  input  wire logic        mclk,
  input  wire logic        hold,        // executor stopped
  input  wire logic        slow,        // executor stalls at random
  input  wire logic        rnd,         // random bit from the bench
  output logic             cmd_valid,
  output status_pkg::cmd_t cmd,
  output logic             exec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_src;  // asking interface of the latest offer, for the bench's notes
  // executor accepts at random while slow, never while held
  assign exec_ready = !hold && (!slow || rnd);
  // one offer stands one cycle; afterwards the lines show junk, not the old value
  task automatic send(input status_pkg::opcode_t op, input logic [7:0] v);
    @(posedge mclk) #1;
    cmd_valid = 1'b1;
    last_src = rnd;
    cmd = '{op: op, value: v, src: last_src};
    @(posedge mclk) #1;
    cmd_valid = 1'b0;
    cmd = '{op: status_pkg::OP_OTHER, value: ~v, src: ~rnd};
  endtask
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
endmodule

// file: sim/event_alarm_status_groups_tb.sv
// event_alarm_status_groups_tb: command scenarios with a reply scoreboard.
// assumes host_model offers commands; replies are checked in order.
module event_alarm_status_groups_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, nvram_blank = 1, hold = 0, slow = 0, rnd = 0;
  logic cmd_valid, exec_ready, sample_valid = 0, queue_full, overflow_err, exec_valid;
  logic reply_valid, std_summary, alarm_summary, srq_opc;
  logic [3:0] errs = 4'h0;                // query, device, exec, command
  logic [6:0] alarm_now = 7'h00, a, b;
  logic [7:0] sre_mask = 8'h00;
  logic [15:0] overflow_code;
  logic [1:0] remote_units;
  logic [31:0] seed = 32'h03ca6017;
  status_pkg::cmd_t cmd, exec_cmd;
  status_pkg::reply_t reply;
  logic [9:0] exp_q[$];                   // asker, units flag and value per query
  int num_errors = 0, checks_done = 0, srq_count = 0, ovf_count = 0;
  always #5 mclk = ~mclk;
  host_model host (.mclk(mclk), .hold(hold), .slow(slow), .rnd(rnd),
    .cmd_valid(cmd_valid), .cmd(cmd), .exec_ready(exec_ready));
  event_alarm_status_groups dut (.mclk(mclk), .reset_n(reset_n), .nvram_blank(nvram_blank),
    .cmd_valid(cmd_valid), .cmd(cmd), .exec_ready(exec_ready), .err_query(errs[0]),
    .err_device(errs[1]), .err_exec(errs[2]), .err_cmd(errs[3]), .sample_valid(sample_valid),
    .alarm_now(alarm_now), .sre_mask(sre_mask), .queue_full(queue_full),
    .overflow_err(overflow_err), .overflow_code(overflow_code), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .reply_valid(reply_valid), .reply(reply), .std_summary(std_summary),
    .alarm_summary(alarm_summary), .srq_opc(srq_opc), .remote_units(remote_units));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // random source advances every cycle
  always @(posedge mclk) begin
    #1 seed = xs(seed);
    rnd <= seed[0];  // lands after the host has sampled the old bit
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // watcher: pulses counted, each reply matched against the oldest note
  always @(posedge mclk) begin
    if (srq_opc === 1'b1) srq_count++;
    if (overflow_err === 1'b1) ovf_count++;
    if (reply_valid === 1'b1)
      check({reply.dst, reply.units, reply.value},
            exp_q.size() ? exp_q.pop_front() : 10'h3ff);
  end
  // bounded wait for the queue to drain and all replies to land
  task automatic idle();
    for (int i = 0; i < 60 && (exec_valid !== 1'b0 || exp_q.size() != 0); i++)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
    check(16'(exp_q.size()), 16'h0000);
  endtask
  task automatic c(input status_pkg::opcode_t op, input logic [7:0] v);
    host.send(op, v);
    idle();
  endtask
  task automatic q(input status_pkg::opcode_t op, input logic [8:0] e);
    host.send(op, 8'h00);
    exp_q.push_back({host.last_src, e});
    idle();
  endtask
  task automatic pulse(input logic [3:0] e, input logic [6:0] al, input logic s);
    @(posedge mclk) #1;
    errs = e;
    alarm_now = al;
    sample_valid = s;
    @(posedge mclk) #1;
    errs = 4'h0;
    sample_valid = 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // short power cycle; blank store only when asked
  task automatic power(input logic blank);
    @(posedge mclk) #1;
    reset_n = 1'b0;
    nvram_blank = blank;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    nvram_blank = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100us num_errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 reset_n = 1'b1;
    nvram_blank = 1'b0;
    q(status_pkg::OP_ESR_Q, 9'h080);
    q(status_pkg::OP_ESR_Q, 9'h000);
    c(status_pkg::OP_ESE, 8'h21);
    q(status_pkg::OP_ESE_Q, 9'h021);
    c(status_pkg::OP_ALM_ENA, 8'hff);
    q(status_pkg::OP_ALM_ENA_Q, 9'h0ff);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 7'h00, 1'b0);
      check(std_summary, i == 3);
      q(status_pkg::OP_ESR_Q, 9'h004 << i);
    end
    $display("test errors done");
    slow = 1'b1;
    a = seed[6:0] | 7'h01;
    b = seed[14:8];
    pulse(4'h0, a, 1'b1);
    pulse(4'h0, b, 1'b1);
    check(alarm_summary, 1'b1);
    q(status_pkg::OP_ALM_CON_Q, {2'b00, b});
    pulse(4'h0, a, 1'b1);
    q(status_pkg::OP_ALM_EVT_Q, {2'b00, a | b});
    q(status_pkg::OP_ALM_EVT_Q, 9'h000);
    check(alarm_summary, 1'b0);
    $display("test alarms done");
    hold = 1'b1;
    sre_mask = 8'h20;
    host.send(status_pkg::OP_ESE, 8'h00);
    host.send(status_pkg::OP_OPC, 8'h00);
    host.send(status_pkg::OP_ESE, 8'h21);
    host.send(status_pkg::OP_OTHER, 8'h00);
    check(queue_full, 1'b1);
    check(16'(exec_cmd.op), 16'(status_pkg::OP_ESE));
    host.send(status_pkg::OP_OTHER, 8'h00);
    hold = 1'b0;
    idle();
    check(16'(ovf_count), 16'h0001);
    check(overflow_code, 16'hfed1);
    check(16'(srq_count), 16'h0000);
    q(status_pkg::OP_ESR_Q, 9'h011);
    c(status_pkg::OP_OPC, 8'h00);
    check(16'(srq_count), 16'h0001);
    q(status_pkg::OP_ESR_Q, 9'h001);
    q(status_pkg::OP_OPC_Q, 9'h001);
    q(status_pkg::OP_ESR_Q, 9'h000);
    $display("test queue done");
    c(status_pkg::OP_PERCENT, 8'h00);
    q(status_pkg::OP_UNITS_Q, {1'b1, 6'h00, status_pkg::UNITS_PERCENT});
    check(remote_units, status_pkg::UNITS_PERCENT);
    pulse(4'h2, 7'h48, 1'b1);
    c(status_pkg::OP_CLS, 8'h00);
    q(status_pkg::OP_ESR_Q, 9'h000);
    q(status_pkg::OP_ALM_EVT_Q, 9'h000);
    $display("test clear done");
    c(status_pkg::OP_PSC, 8'h00);
    power(1'b0);
    q(status_pkg::OP_ESE_Q, 9'h021);
    q(status_pkg::OP_ALM_ENA_Q, 9'h0ff);
    check(remote_units, status_pkg::UNITS_PERCENT);
    c(status_pkg::OP_PSC, 8'h01);
    power(1'b0);
    q(status_pkg::OP_ESE_Q, 9'h000);
    q(status_pkg::OP_ALM_ENA_Q, 9'h000);
    q(status_pkg::OP_ESR_Q, 9'h080);
    $display("test power done");
    test_done();
  end
endmodule
